// File: tap_event_config_status.sv
// Tap detector configuration and clear-on-read status registers
`timescale 1ns/10ps
module tap_event_config_status (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register port of the serial interface engine
  input wire logic [tap_pkg::REG_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [tap_pkg::REG_W-1:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [tap_pkg::REG_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Pulse detector results
  input wire logic i_sample_tick,
  input wire logic i_pulse_start,
  input wire logic i_pulse_done,
  input wire logic [tap_pkg::AXES-1:0] i_pulse_axes,
  input wire logic [tap_pkg::AXES-1:0] i_pulse_neg,
  input wire logic [tap_pkg::REG_W-1:0] i_latency_steps,
  input wire logic [tap_pkg::REG_W-1:0] i_window_steps,
  // Interrupt
  output logic o_tap_irq
);
  import tap_pkg::*;

  // Address match shared by the strobes and the read checks; the read mux decodes the address itself
  function automatic logic addr_is(input logic [REG_W-1:0] addr,
                                   input logic [REG_W-1:0] ofs);
    return (addr == ofs);
  endfunction : addr_is

  logic [REG_W-1:0] cfg_ff;
  logic [REG_W-1:0] status_ff;
  logic irq_ff;
  logic [REG_W-1:0] rdata_ff;
  logic rvalid_ff;
  logic rd_status;
  logic wr_cfg;
  logic latch_en;
  logic frozen;
  logic load_evt;

  tap_evt_if evt_bus ();

  tap_pulse_seq u_seq (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_sample_tick(i_sample_tick),
    .i_pulse_start(i_pulse_start),
    .i_pulse_done(i_pulse_done),
    .i_pulse_axes(i_pulse_axes),
    .i_pulse_neg(i_pulse_neg),
    .i_latency_steps(i_latency_steps),
    .i_window_steps(i_window_steps),
    .evt(evt_bus.seq)
  );

  assign evt_bus.cfg = cfg_ff;
  assign rd_status = i_reg_rd && addr_is(i_reg_addr, ADDR_TAP_STATUS);
  assign wr_cfg = i_reg_wr && addr_is(i_reg_addr, ADDR_TAP_CFG);
  assign latch_en = cfg_ff[CFG_LATCH_BIT];
  assign frozen = latch_en && status_ff[ST_ACTIVE_BIT];
  // A read in the same cycle releases the freeze so the event is kept
  assign load_evt = evt_bus.evt_valid && (!frozen || rd_status);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_ff <= TAP_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_ff <= i_reg_wdata;
    end
  end

  // Writes to the status address fall through untouched
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      status_ff <= TAP_STATUS_RESET;
    end else if (load_evt) begin
      // Set beats clear; unlatched mode reloads on every event
      status_ff[ST_ACTIVE_BIT] <= 1'b1;
      status_ff[ST_AXES_LSB +: AXES] <= evt_bus.evt_axes;
      status_ff[ST_DOUBLE_BIT] <= evt_bus.evt_double;
      status_ff[ST_DIR_LSB +: AXES] <= evt_bus.evt_neg;
    end else if (rd_status) begin
      status_ff <= TAP_STATUS_RESET;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_ff <= 1'b0;
    end else if (load_evt) begin
      irq_ff <= 1'b1;
    end else if (rd_status) begin
      irq_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= i_reg_rd;
    end
  end

  // Read data is captured before the clear takes effect
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= '0;
    end else begin
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          ADDR_TAP_CFG: rdata_ff <= cfg_ff;
          ADDR_TAP_STATUS: rdata_ff <= status_ff;
          default: rdata_ff <= '0;
        endcase
      end
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_reg_rvalid = rvalid_ff;
  assign o_tap_irq = irq_ff;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  cfg_write_a: assert property (
    wr_cfg |=> (cfg_ff == $past(i_reg_wdata)))
    else $error("configuration write not stored");
  read_clear_a: assert property (
    rd_status && !evt_bus.evt_valid |=> (status_ff == '0) ##0 !o_tap_irq)
    else $error("status read did not clear all bits");
  irq_ack_a: assert property (
    rd_status && !evt_bus.evt_valid |=> !o_tap_irq [*1] ##1
    (o_tap_irq -> $past(load_evt)))
    else $error("interrupt not deasserted by status read");
  event_set_a: assert property (
    evt_bus.evt_valid && !frozen |=> status_ff[ST_ACTIVE_BIT] && o_tap_irq)
    else $error("event did not raise active flag and interrupt");
  freeze_hold_a: assert property (
    frozen && !rd_status |=> $stable(status_ff))
    else $error("latched status changed before read");
  latched_keep_a: assert property (
    frozen && !rd_status [*2] |=> status_ff[ST_ACTIVE_BIT])
    else $error("latched flag lost without read");
  follow_latest_a: assert property (
    !latch_en && evt_bus.evt_valid |=>
    (status_ff[ST_AXES_LSB +: AXES] == $past(evt_bus.evt_axes)) &&
    (status_ff[ST_DOUBLE_BIT] == $past(evt_bus.evt_double)) &&
    (status_ff[ST_DIR_LSB +: AXES] == $past(evt_bus.evt_neg)))
    else $error("unlatched status did not follow latest event");
  status_wr_a: assert property (
    i_reg_wr && (i_reg_addr == ADDR_TAP_STATUS) && !evt_bus.evt_valid &&
    !i_reg_rd |=> $stable(status_ff))
    else $error("write changed read-only status");
  read_data_a: assert property (
    rd_status |=> o_reg_rvalid && (o_reg_rdata == $past(status_ff)))
    else $error("status read returned wrong data");
  // Register port answers
  cfg_hold_a: assert property (
    !wr_cfg |=> $stable(cfg_ff))
    else $error("configuration changed without a write");
  cfg_read_a: assert property (
    i_reg_rd && addr_is(i_reg_addr, ADDR_TAP_CFG) |=>
    (o_reg_rdata == $past(cfg_ff)))
    else $error("configuration read returned wrong data");
  unmapped_read_a: assert property (
    i_reg_rd && !addr_is(i_reg_addr, ADDR_TAP_CFG) &&
    !addr_is(i_reg_addr, ADDR_TAP_STATUS) |=> (o_reg_rdata == '0))
    else $error("unmapped read returned nonzero data");
  rvalid_rise_a: assert property (
    i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered in the next cycle");
  rvalid_idle_a: assert property (
    !i_reg_rd |=> !o_reg_rvalid)
    else $error("read valid without a read");
  rdata_hold_a: assert property (
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");
  wr_irq_keep_a: assert property (
    i_reg_wr && addr_is(i_reg_addr, ADDR_TAP_STATUS) && !load_evt &&
    !i_reg_rd |=> $stable(o_tap_irq))
    else $error("status write touched the interrupt");
  // Status byte consistency
  irq_active_a: assert property (
    o_tap_irq == status_ff[ST_ACTIVE_BIT])
    else $error("interrupt and active flag disagree");
  irq_rise_a: assert property (
    $rose(o_tap_irq) |-> $past(load_evt))
    else $error("interrupt raised without an event");
  active_rise_a: assert property (
    $rose(status_ff[ST_ACTIVE_BIT]) |-> $past(load_evt))
    else $error("active flag set without an event");
  axes_active_a: assert property (
    status_ff[ST_ACTIVE_BIT] == (status_ff[ST_AXES_LSB +: AXES] != '0))
    else $error("active flag without fired axis");
  axes_load_a: assert property (
    load_evt |=>
    (status_ff[ST_AXES_LSB +: AXES] == $past(evt_bus.evt_axes)))
    else $error("fired axes not loaded from event");
  double_load_a: assert property (
    load_evt |=>
    (status_ff[ST_DOUBLE_BIT] == $past(evt_bus.evt_double)))
    else $error("tap type not loaded from event");
  dir_load_a: assert property (
    load_evt |=>
    (status_ff[ST_DIR_LSB +: AXES] == $past(evt_bus.evt_neg)))
    else $error("tap direction not loaded from event");
  double_active_a: assert property (
    status_ff[ST_DOUBLE_BIT] |-> status_ff[ST_ACTIVE_BIT])
    else $error("double tap flag without active flag");
  dir_on_axes_a: assert property (
    (status_ff[ST_DIR_LSB +: AXES] & ~status_ff[ST_AXES_LSB +: AXES]) == '0)
    else $error("direction reported for an axis that did not fire");
  quiet_hold_a: assert property (
    !rd_status && !load_evt |=> $stable(status_ff))
    else $error("status changed without event or read");
  latched_irq_a: assert property (
    frozen && !rd_status |=> o_tap_irq)
    else $error("latched interrupt dropped without read");
  no_enable_a: assert property (
    (cfg_ff[CFG_EN_STRIDE*AXES-1:0] == '0) |=> !evt_bus.evt_valid)
    else $error("tap event with every enable cleared");
  latched_read_c: cover property (frozen ##[1:20] rd_status);
  set_clear_c: cover property (rd_status && evt_bus.evt_valid);
  unlatched_c: cover property (!latch_en && evt_bus.evt_valid);
endmodule : tap_event_config_status

// File: tap_pkg.sv
// Constants shared by the tap event configuration and status logic
// Contract
// - Six per-axis single/double tap enables, default off
// - Status event only when axis and type enabled
// - Abort clear: pulses inside latency keep double detection
// - Abort set: pulse within latency suspends double detection
// - Latch enabled: flags held until status read
// - Status bit 7 flags any generated event
// - Bits 6..4 report Z, Y, X axis fired
// - Bit 3: zero single tap, one double tap
// - Bits 2..0 Z, Y, X direction, one negative
// - Latched active flag freezes axis, type, direction bits
// - Host status read clears every status bit
// - Status read deasserts the tap interrupt
// - Latency interval after first tap ignores pulses
package tap_pkg;
  localparam int REG_W = 8;
  localparam int AXES = 3;
  localparam logic [7:0] ADDR_TAP_CFG = 8'h21;
  localparam logic [7:0] ADDR_TAP_STATUS = 8'h22;
  localparam logic [7:0] TAP_CFG_RESET = 8'h00;
  localparam logic [7:0] TAP_STATUS_RESET = 8'h00;
  // Configuration fields
  localparam int CFG_ABORT_BIT = 7;
  localparam int CFG_LATCH_BIT = 6;
  localparam int CFG_EN_STRIDE = 2;
  localparam int CFG_SINGLE_OFS = 0;
  localparam int CFG_DOUBLE_OFS = 1;
  // Status fields
  localparam int ST_ACTIVE_BIT = 7;
  localparam int ST_AXES_LSB = 4;
  localparam int ST_DOUBLE_BIT = 3;
  localparam int ST_DIR_LSB = 0;
  localparam logic [7:0] STEPS_RESET = 8'h00;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_LATENCY = 3'b010,
    SEQ_SECOND = 3'b100
  } seq_state_e;
endpackage : tap_pkg

// File: tap_evt_if.sv
// Configuration and qualified tap events between bank and sequencer
`timescale 1ns/10ps
interface tap_evt_if;
  import tap_pkg::*;
  logic [REG_W-1:0] cfg;
  logic evt_valid;
  logic evt_double;
  logic [AXES-1:0] evt_axes;
  logic [AXES-1:0] evt_neg;
  modport bank (output cfg, input evt_valid, input evt_double,
                input evt_axes, input evt_neg);
  modport seq (input cfg, output evt_valid, output evt_double,
               output evt_axes, output evt_neg);
endinterface : tap_evt_if

// File: tap_pulse_seq.sv
// Single/double tap qualification with latency window and abort
`timescale 1ns/10ps
module tap_pulse_seq (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Pulse detector results, same clock domain
  input wire logic i_sample_tick,
  input wire logic i_pulse_start,
  input wire logic i_pulse_done,
  input wire logic [tap_pkg::AXES-1:0] i_pulse_axes,
  input wire logic [tap_pkg::AXES-1:0] i_pulse_neg,
  input wire logic [tap_pkg::REG_W-1:0] i_latency_steps,
  input wire logic [tap_pkg::REG_W-1:0] i_window_steps,
  // Bank side
  tap_evt_if.seq evt
);
  import tap_pkg::*;

  seq_state_e state_ff;
  logic [REG_W-1:0] cnt_ff;
  logic start_seen_ff;
  logic evt_valid_ff;
  logic evt_double_ff;
  logic [AXES-1:0] evt_axes_ff;
  logic [AXES-1:0] evt_neg_ff;
  logic [AXES-1:0] single_mask;
  logic [AXES-1:0] double_mask;
  logic [AXES-1:0] single_hit;
  logic [AXES-1:0] double_hit;
  logic abort_now;

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_mask
      assign single_mask[g] = evt.cfg[g*CFG_EN_STRIDE + CFG_SINGLE_OFS];
      assign double_mask[g] = evt.cfg[g*CFG_EN_STRIDE + CFG_DOUBLE_OFS];
    end
  endgenerate

  assign single_hit = i_pulse_axes & single_mask;
  assign double_hit = i_pulse_axes & double_mask;
  // Pulse both began and ended inside the latency window
  assign abort_now = evt.cfg[CFG_ABORT_BIT] && i_pulse_done &&
                     (start_seen_ff || i_pulse_start);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= SEQ_IDLE;
      cnt_ff <= STEPS_RESET;
    end else begin
      unique case (state_ff)
        SEQ_IDLE: begin
          if (i_pulse_done && (double_hit != '0)) begin
            state_ff <= SEQ_LATENCY;
            cnt_ff <= i_latency_steps;
          end
        end
        SEQ_LATENCY: begin
          // Without abort, pulses here are simply ignored
          if (abort_now) begin
            state_ff <= SEQ_IDLE;
          end else if (i_sample_tick) begin
            if (cnt_ff == '0) begin
              state_ff <= SEQ_SECOND;
              cnt_ff <= i_window_steps;
            end else begin
              cnt_ff <= cnt_ff - 8'h01;
            end
          end
        end
        SEQ_SECOND: begin
          if (i_pulse_done) begin
            state_ff <= SEQ_IDLE;
          end else if (i_sample_tick) begin
            if (cnt_ff == '0) begin
              state_ff <= SEQ_IDLE;
            end else begin
              cnt_ff <= cnt_ff - 8'h01;
            end
          end
        end
        default: begin
          state_ff <= SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      start_seen_ff <= 1'b0;
    end else begin
      start_seen_ff <= (state_ff == SEQ_LATENCY) &&
                       (start_seen_ff || i_pulse_start) && !abort_now;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      evt_valid_ff <= 1'b0;
      evt_double_ff <= 1'b0;
      evt_axes_ff <= '0;
      evt_neg_ff <= '0;
    end else begin
      evt_valid_ff <= 1'b0;
      if (i_pulse_done && state_ff == SEQ_IDLE && single_hit != '0) begin
        evt_valid_ff <= 1'b1;
        evt_double_ff <= 1'b0;
        evt_axes_ff <= single_hit;
        evt_neg_ff <= i_pulse_neg & single_hit;
      end else if (i_pulse_done && state_ff == SEQ_SECOND &&
                   double_hit != '0) begin
        evt_valid_ff <= 1'b1;
        evt_double_ff <= 1'b1;
        evt_axes_ff <= double_hit;
        evt_neg_ff <= i_pulse_neg & double_hit;
      end
    end
  end

  assign evt.evt_valid = evt_valid_ff;
  assign evt.evt_double = evt_double_ff;
  assign evt.evt_axes = evt_axes_ff;
  assign evt.evt_neg = evt_neg_ff;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  latency_quiet_a: assert property (
    (state_ff == SEQ_LATENCY) |=> !evt_valid_ff)
    else $error("tap event emitted from inside latency window");
  abort_stop_a: assert property (
    (state_ff == SEQ_LATENCY) && abort_now |=> (state_ff == SEQ_IDLE))
    else $error("abort did not suspend double tap detection");
  no_abort_keep_a: assert property (
    (state_ff == SEQ_LATENCY) && !evt.cfg[CFG_ABORT_BIT] &&
    i_pulse_done && !i_sample_tick |=> (state_ff == SEQ_LATENCY))
    else $error("pulse in latency ended double detection without abort");
  enable_gate_a: assert property (
    evt_valid_ff |-> (evt_axes_ff != '0) &&
    ((evt_axes_ff & ~(evt_double_ff ? $past(double_mask)
                                    : $past(single_mask))) == '0))
    else $error("tap event on disabled axis or type");
  double_seen_c: cover property (
    (state_ff == SEQ_SECOND) ##1 (evt_valid_ff && evt_double_ff));
  abort_seen_c: cover property (
    (state_ff == SEQ_LATENCY) && abort_now);
endmodule : tap_pulse_seq

// File: tap_host_model.sv
// Host register master standing in for the serial engine side
`timescale 1ns/10ps
module tap_host_model (
  // Clock
  input wire logic i_core_clk,
  // Register port towards the device
  output logic [tap_pkg::REG_W-1:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [tap_pkg::REG_W-1:0] o_reg_wdata,
  output logic o_reg_rd,
  input wire logic [tap_pkg::REG_W-1:0] i_reg_rdata,
  input wire logic i_reg_rvalid
);
  import tap_pkg::*;
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_core_clk) #1;
    o_reg_addr = addr;
    o_reg_wdata = data;
    o_reg_wr = 1'b1;
    @(posedge i_core_clk) #1;
    o_reg_wr = 1'b0;
    // Released data bus shows the inverse, not the stale byte
    o_reg_wdata = ~data;
  endtask : wr_reg
  // Only a completed read strobe is issued, which is what clears status
  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data,
                        output bit ok);
    int n;
    @(posedge i_core_clk) #1;
    o_reg_addr = addr;
    o_reg_rd = 1'b1;
    @(posedge i_core_clk) #1;
    o_reg_rd = 1'b0;
    ok = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      if (i_reg_rvalid === 1'b1) begin
        ok = 1'b1;
        data = i_reg_rdata;
      end else begin
        @(posedge i_core_clk) #1;
      end
    end
  endtask : rd_reg
endmodule : tap_host_model

// File: tap_event_config_status_tb.sv
// Self-checking bench for the tap configuration and status registers
`timescale 1ns/10ps
module tap_event_config_status_tb;
  import tap_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_sample_tick = 1'b0;
  logic i_pulse_start = 1'b0;
  logic i_pulse_done = 1'b0;
  logic [2:0] i_pulse_axes = 3'h0;
  logic [2:0] i_pulse_neg = 3'h0;
  logic [7:0] latency_steps = 8'h02;
  logic [7:0] window_steps = 8'h04;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic reg_rvalid;
  logic tap_irq;
  int fail_count = 0;
  int samples_checked = 0;
  always #50 i_core_clk = ~i_core_clk;
  tap_event_config_status u_tap_event_config_status (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(reg_addr),
    .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
    .i_sample_tick(i_sample_tick), .i_pulse_start(i_pulse_start),
    .i_pulse_done(i_pulse_done), .i_pulse_axes(i_pulse_axes),
    .i_pulse_neg(i_pulse_neg), .i_latency_steps(latency_steps),
    .i_window_steps(window_steps), .o_tap_irq(tap_irq));
  tap_host_model u_tap_host_model (
    .i_core_clk(i_core_clk), .o_reg_addr(reg_addr), .o_reg_wr(reg_wr),
    .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd), .i_reg_rdata(reg_rdata),
    .i_reg_rvalid(reg_rvalid));
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp,
                          input string name);
    logic [7:0] data;
    bit ok;
    u_tap_host_model.rd_reg(addr, data, ok);
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen no answer", name, exp);
      print_verdict();
    end else begin
      check(name, exp, data);
    end
  endtask : rd_check
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_core_clk) #1;
      i_sample_tick = 1'b1;
      @(posedge i_core_clk) #1;
      i_sample_tick = 1'b0;
    end
  endtask : ticks
  // Start and end of one pulse; the detector hands axes with the end
  task automatic pulse(input logic [2:0] axes, input logic [2:0] neg);
    @(posedge i_core_clk) #1;
    i_pulse_start = 1'b1;
    @(posedge i_core_clk) #1;
    i_pulse_start = 1'b0;
    i_pulse_done = 1'b1;
    i_pulse_axes = axes;
    i_pulse_neg = neg;
    @(posedge i_core_clk) #1;
    i_pulse_done = 1'b0;
    i_pulse_axes = ~axes;
    i_pulse_neg = ~neg;
  endtask : pulse
  task automatic test_reset();
    rd_check(ADDR_TAP_CFG, 8'h00, "cfg reset");
    rd_check(ADDR_TAP_STATUS, 8'h00, "status reset");
    rd_check(8'h30, 8'h00, "unmapped read");
    check("irq reset", 8'h00, {7'h0, tap_irq});
  endtask : test_reset
  task automatic test_writes();
    u_tap_host_model.wr_reg(ADDR_TAP_STATUS, 8'hff);
    rd_check(ADDR_TAP_STATUS, 8'h00, "status write ignored");
    u_tap_host_model.wr_reg(ADDR_TAP_CFG, 8'hc3);
    rd_check(ADDR_TAP_CFG, 8'hc3, "cfg read back");
  endtask : test_writes
  // Disabled axes and types must stay out of the status byte
  task automatic test_enables();
    int i;
    u_tap_host_model.wr_reg(ADDR_TAP_CFG, 8'h00);
    pulse(3'h7, 3'h7);
    ticks(8);
    rd_check(ADDR_TAP_STATUS, 8'h00, "all disabled");
    for (i = 0; i < 3; i++) begin
      u_tap_host_model.wr_reg(ADDR_TAP_CFG, 8'h01 << (2 * i));
      pulse(3'h7, 3'h7);
      ticks(8);
      check("irq set", 8'h01, {7'h0, tap_irq});
      rd_check(ADDR_TAP_STATUS, 8'h80 | (8'h11 << i), "one axis");
      check("irq cleared", 8'h00, {7'h0, tap_irq});
    end
  endtask : test_enables
  task automatic test_latch();
    u_tap_host_model.wr_reg(ADDR_TAP_CFG, 8'h45);
    pulse(3'h1, 3'h0);
    ticks(8);
    pulse(3'h2, 3'h2);
    ticks(8);
    rd_check(ADDR_TAP_STATUS, 8'h90, "frozen status");
    rd_check(ADDR_TAP_STATUS, 8'h00, "cleared status");
    check("irq after read", 8'h00, {7'h0, tap_irq});
  endtask : test_latch
  task automatic test_follow();
    u_tap_host_model.wr_reg(ADDR_TAP_CFG, 8'h05);
    pulse(3'h1, 3'h0);
    ticks(8);
    pulse(3'h2, 3'h2);
    ticks(8);
    rd_check(ADDR_TAP_STATUS, 8'ha2, "latest event");
    rd_check(ADDR_TAP_STATUS, 8'h00, "unlatched clear");
  endtask : test_follow
  // Pulse inside latency, then second tap in the window
  task automatic double_seq(input logic [7:0] cfg, input logic [7:0] exp,
                            input string name);
    u_tap_host_model.wr_reg(ADDR_TAP_CFG, cfg);
    pulse(3'h1, 3'h1);
    ticks(1);
    pulse(3'h1, 3'h1);
    ticks(2);
    pulse(3'h1, 3'h1);
    ticks(8);
    rd_check(ADDR_TAP_STATUS, exp, name);
  endtask : double_seq
  initial begin
    repeat (12) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    test_reset();
    test_writes();
    test_enables();
    test_latch();
    test_follow();
    double_seq(8'h02, 8'h99, "double kept");
    double_seq(8'h82, 8'h00, "double aborted");
    print_verdict();
  end
endmodule : tap_event_config_status_tb
